// [rtl/stw_cap_sense.sv]
// One-shot timing capacitor sense: one charge and one discharge per start pulse.
// Assumes an external comparator reports the capacitor above its reference (synchronised).
`timescale 1ns/1ps
`include "stw_map.svh"
module stw_cap_sense #(
	parameter int CNT_W = 24,
	parameter logic [23:0] MAX_CHARGE = 24'(`STW_CAP_MAX_CHARGE_CYCLES),
	parameter logic [23:0] DISCHARGE = 24'(`STW_CAP_DISCHARGE_CYCLES)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control and comparator
	input wire logic start,
	input wire logic aboveRef,
	// Pin drivers
	output logic capCharge,
	output logic capDischarge,
	// Result, held until the next start
	output logic [CNT_W-1:0] chargeCount_q,
	output logic capOk_q,
	output logic capDone_q
);

	stw_types_pkg::stw_cap_state_t state_q;
	logic [23:0] timer_q;

	// Sense cycle; the result is never refreshed while idle, so a swapped
	// capacitor only counts after the next start
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state_q <= stw_types_pkg::CAP_IDLE;
			timer_q <= 24'h0;
			chargeCount_q <= '0;
			capOk_q <= 1'b0;
			capDone_q <= 1'b0;
		end
		else if (start)
		begin
			state_q <= stw_types_pkg::CAP_CHARGE;
			timer_q <= 24'h0;
			capDone_q <= 1'b0;
			capOk_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				stw_types_pkg::CAP_CHARGE:
				begin
					// Too large or shorted: never reaches the reference in time
					if (aboveRef || timer_q == MAX_CHARGE)
					begin
						capOk_q <= aboveRef && timer_q != 24'h0;
						chargeCount_q <= CNT_W'(timer_q);
						timer_q <= 24'h0;
						state_q <= stw_types_pkg::CAP_DISCHARGE;
					end
					else
						timer_q <= timer_q + 24'h1;
				end
				stw_types_pkg::CAP_DISCHARGE:
				begin
					if (timer_q == DISCHARGE)
					begin
						capDone_q <= 1'b1;
						state_q <= stw_types_pkg::CAP_IDLE;
					end
					else
						timer_q <= timer_q + 24'h1;
				end
				default:
					state_q <= stw_types_pkg::CAP_IDLE;
			endcase
		end
	end

	assign capCharge = state_q == stw_types_pkg::CAP_CHARGE;
	assign capDischarge = state_q == stw_types_pkg::CAP_DISCHARGE;

endmodule

// [rtl/stw_map.svh]
// Offsets-free constant map of the supervisor watchdog: timing figures and field codes.
// Assumes a 10 MHz core clock; every cycle count except the capacitor sense counts is derived from a time and that rate.
`ifndef STW_MAP_SVH
`define STW_MAP_SVH

// Core clock rate in MHz and counter width (640 s needs 33 bits at 10 MHz)
`define STW_CLOCK_MHZ 10
`define STW_CNT_W 34

// Power-up settle time, added to the hold time after a power-on event
`define STW_SETTLE_TIME_US 500
`define STW_SETTLE_CYCLES (`STW_SETTLE_TIME_US * `STW_CLOCK_MHZ)

// Fixed hold time used when the hold capacitor pin is open
`define STW_OPEN_HOLD_TIME_MS 2
`define STW_OPEN_HOLD_CYCLES (`STW_OPEN_HOLD_TIME_MS * 1000 * `STW_CLOCK_MHZ)

// Factory hold, base window and boot grace times (plain defaults)
`define STW_HOLD_TIME_MS 200
`define STW_HOLD_CYCLES (`STW_HOLD_TIME_MS * 1000 * `STW_CLOCK_MHZ)
`define STW_WINDOW_BASE_TIME_MS 100
`define STW_WINDOW_BASE_CYCLES (`STW_WINDOW_BASE_TIME_MS * 1000 * `STW_CLOCK_MHZ)
`define STW_GRACE_TIME_MS 200
`define STW_GRACE_CYCLES (`STW_GRACE_TIME_MS * 1000 * `STW_CLOCK_MHZ)

// Upper clamp on the scaled window
`define STW_WINDOW_MAX_S 640

// Window per farad (4.95e6 s/F) and charge time per farad of the sense cycle, both x100
`define STW_CAP_FACTOR_X100 495000000
`define STW_CAP_CHARGE_SPF_X100 4950000
`define STW_CAP_MAX_CHARGE_CYCLES 200000
`define STW_CAP_DISCHARGE_CYCLES 100

// Scale multiplier exponent and the disabling scale code
`define STW_SCALE_SHIFT 1
`define STW_SCALE_CODE_DISABLE 2'h1

`endif

// [rtl/stw_pin_sync.sv]
// Two-flop synchroniser bank with falling-edge detect on the synchronised levels.
// Assumes pins are asynchronous to clock; reset clears every stage to low.
`timescale 1ns/1ps
module stw_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Raw pins
	input wire logic [WIDTH-1:0] pinsIn,
	// Synchronised levels and one-cycle falling pulses
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fell
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	// First stage feeds only the second; edge logic looks at the later stages
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			meta_q <= pinsIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// High sample followed by low sample; reset low so no false edge at start
	assign level = sync_q;
	assign fell = prev_q & ~sync_q;

endmodule

// [rtl/stw_supervisor_watchdog.sv]
// Undervoltage supervisor reset sequencer with a timeout watchdog.
// Assumes comparator levels and host pins arrive asynchronously; variant straps are static.
`timescale 1ns/1ps
`include "stw_map.svh"
module stw_supervisor_watchdog #(
	parameter logic [33:0] HOLD_CYCLES = 34'(`STW_HOLD_CYCLES),
	parameter logic [33:0] SETTLE_CYCLES = 34'(`STW_SETTLE_CYCLES),
	parameter logic [33:0] OPEN_HOLD_CYCLES = 34'(`STW_OPEN_HOLD_CYCLES),
	parameter logic [33:0] WINDOW_BASE_CYCLES = 34'(`STW_WINDOW_BASE_CYCLES),
	parameter logic [33:0] GRACE_CYCLES = 34'(`STW_GRACE_CYCLES),
	parameter int SCALE_SHIFT = `STW_SCALE_SHIFT
) (
	// Clock and power-on reset
	input wire logic clock,
	input wire logic reset_n,
	// Supply comparator levels
	input wire logic supplyBelowFalling,
	input wire logic supplyAboveRising,
	// Host pins
	input wire logic kickInput,
	input wire logic watchdogEnablePin,
	input wire logic scaleSelectBit0,
	input wire logic scaleSelectBit1,
	// Capacitor pins
	input wire logic windowCapAboveRef,
	input wire logic holdCapacitorOpen,
	output logic windowCapCharge,
	output logic windowCapDischarge,
	// Variant straps
	input wire logic dualOutputPinout,
	input wire logic hasEnablePin,
	input wire logic hasScaleBit1,
	input wire logic capWindowMode,
	input wire logic capHoldMode,
	// Outputs
	output logic resetOut_n,
	output logic watchdogFaultOut_n
);

	localparam logic [33:0] WIN_MAX =
		34'(64'(`STW_WINDOW_MAX_S) * 64'd1000000 * 64'(`STW_CLOCK_MHZ));
	localparam logic [33:0] CAP_MULT =
		34'(`STW_CAP_FACTOR_X100 / `STW_CAP_CHARGE_SPF_X100);

	logic [7:0] pinLevel;
	logic [7:0] pinFell;
	logic kickFell;
	logic belowFall;
	logic aboveRise;
	logic holdOpen;
	logic [1:0] scaleCode;
	logic [23:0] capCount;
	logic capOk;
	logic capDone;
	logic methodEn;
	logic wdEnabled;
	logic supOk;
	logic goHold;
	logic [33:0] holdSel;
	logic [33:0] baseWindow;
	logic [33:0] winLenNow;
	logic [33:0] winLenLast_q;
	logic cfgChange;
	stw_types_pkg::stw_sup_state_t supState_q;
	stw_types_pkg::stw_wd_state_t wdState_q;
	logic [33:0] holdCount_q;
	logic [33:0] holdTarget_q;
	logic porFlag_q;
	logic [33:0] wdCount_q;
	logic [33:0] windowTarget_q;

	// Scaled and clamped window length for a scale code
	function automatic logic [33:0] scaledWindow(input logic [33:0] base, input logic [1:0] code,
		input logic twoPins);
		logic [63:0] wide;
		wide = 64'(base);
		if (twoPins && code == 2'h3)
			wide = wide << (SCALE_SHIFT + 1);
		else if ((twoPins && code == 2'h2) || (!twoPins && code[0]))
			wide = wide << SCALE_SHIFT;
		if (wide > 64'(WIN_MAX))
			wide = 64'(WIN_MAX);
		return wide[33:0];
	endfunction

	// Every pin passes two flops before use
	stw_pin_sync #(
		.WIDTH(8)
	) i_stw_pin_sync (
		.clock(clock),
		.reset_n(reset_n),
		.pinsIn({holdCapacitorOpen, windowCapAboveRef, supplyAboveRising, supplyBelowFalling,
			scaleSelectBit1, scaleSelectBit0, watchdogEnablePin, kickInput}),
		.level(pinLevel),
		.fell(pinFell)
	);

	// Synchronised views; the kick edge is only as early as the host
	assign kickFell = pinFell[0];
	assign belowFall = pinLevel[4];
	assign aboveRise = pinLevel[5];
	assign holdOpen = pinLevel[7];
	assign scaleCode = hasScaleBit1 ? pinLevel[3:2] : {1'b0, pinLevel[2]};

	// Capacitor sensed once on each recovery from low supply
	stw_cap_sense #(
		.CNT_W(24)
	) i_stw_cap_sense (
		.clock(clock),
		.reset_n(reset_n),
		.start(goHold),
		.aboveRef(pinLevel[6]),
		.capCharge(windowCapCharge),
		.capDischarge(windowCapDischarge),
		.chargeCount_q(capCount),
		.capOk_q(capOk),
		.capDone_q(capDone)
	);

	// Enable: one method per pinout, capacitor disable overrides both
	always_comb
	begin
		if (hasEnablePin)
			methodEn = pinLevel[1];
		else if (hasScaleBit1)
			methodEn = scaleCode != `STW_SCALE_CODE_DISABLE;
		else
			methodEn = 1'b1;
		wdEnabled = methodEn && (!capWindowMode || (capDone && capOk));
	end

	// Window length from capacitor or factory base, then scaled
	assign baseWindow = capWindowMode ? 34'(capCount) * CAP_MULT : WINDOW_BASE_CYCLES;
	assign winLenNow = scaledWindow(baseWindow, scaleCode, hasScaleBit1);
	// A change that leaves the length alone (01 beside the enable pin) is not a change
	assign cfgChange = winLenNow != winLenLast_q;

	// Hold time: fixed short hold when the hold capacitor is open
	assign holdSel = (capHoldMode && holdOpen) ? OPEN_HOLD_CYCLES : HOLD_CYCLES;
	assign goHold = supState_q == stw_types_pkg::SUP_LOW && aboveRise && !belowFall;
	assign supOk = supState_q == stw_types_pkg::SUP_OK;

	// Window length of the previous cycle, tracked every cycle for change detect
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			winLenLast_q <= 34'h0;
		else
			winLenLast_q <= winLenNow;
	end

	// Supervisor sequencer; power-on adds the settle time to every hold until the first release
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			supState_q <= stw_types_pkg::SUP_LOW;
			holdCount_q <= 34'h0;
			holdTarget_q <= 34'h0;
			porFlag_q <= 1'b1;
		end
		else
		begin
			case (supState_q)
				stw_types_pkg::SUP_LOW:
				begin
					if (goHold)
					begin
						supState_q <= stw_types_pkg::SUP_HOLD;
						holdCount_q <= 34'h0;
						holdTarget_q <= porFlag_q ? SETTLE_CYCLES + holdSel : holdSel;
					end
				end
				stw_types_pkg::SUP_HOLD:
				begin
					if (belowFall)
						supState_q <= stw_types_pkg::SUP_LOW;
					else if (holdCount_q + 34'h1 >= holdTarget_q)
					begin
						supState_q <= stw_types_pkg::SUP_OK;
						porFlag_q <= 1'b0;
					end
					else
						holdCount_q <= holdCount_q + 34'h1;
				end
				stw_types_pkg::SUP_OK:
				begin
					if (belowFall)
						supState_q <= stw_types_pkg::SUP_LOW;
				end
				default:
					supState_q <= stw_types_pkg::SUP_LOW;
			endcase
		end
	end

	// Watchdog phases; everything is parked while the supervisor holds reset
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			wdState_q <= stw_types_pkg::WD_OFF;
			wdCount_q <= 34'h0;
			windowTarget_q <= 34'h0;
		end
		else if (!supOk)
		begin
			wdState_q <= stw_types_pkg::WD_OFF;
			wdCount_q <= 34'h0;
		end
		else
		begin
			case (wdState_q)
				stw_types_pkg::WD_OFF:
				begin
					wdCount_q <= 34'h0;
					wdState_q <= wdEnabled ? stw_types_pkg::WD_GRACE
						: stw_types_pkg::WD_IDLE;
				end
				stw_types_pkg::WD_IDLE:
				begin
					if (wdEnabled)
					begin
						wdState_q <= stw_types_pkg::WD_WINDOW;
						wdCount_q <= 34'h0;
						windowTarget_q <= winLenNow;
					end
				end
				stw_types_pkg::WD_GRACE:
				begin
					if (!wdEnabled)
						wdState_q <= stw_types_pkg::WD_IDLE;
					else if (kickFell || cfgChange)
					begin
						wdState_q <= stw_types_pkg::WD_WINDOW;
						wdCount_q <= 34'h0;
						windowTarget_q <= winLenNow;
					end
					else if (wdCount_q + 34'h1 >= GRACE_CYCLES)
					begin
						wdState_q <= stw_types_pkg::WD_FAULT;
						wdCount_q <= 34'h0;
					end
					else
						wdCount_q <= wdCount_q + 34'h1;
				end
				stw_types_pkg::WD_WINDOW:
				begin
					if (!wdEnabled)
						wdState_q <= stw_types_pkg::WD_IDLE;
					else if (kickFell || cfgChange)
					begin
						wdCount_q <= 34'h0;
						windowTarget_q <= winLenNow;
					end
					else if (wdCount_q + 34'h1 >= windowTarget_q)
					begin
						wdState_q <= stw_types_pkg::WD_FAULT;
						wdCount_q <= 34'h0;
					end
					else
						wdCount_q <= wdCount_q + 34'h1;
				end
				stw_types_pkg::WD_FAULT:
				begin
					// Scale changes here are only picked up when the next window starts
					if (!wdEnabled)
						wdState_q <= stw_types_pkg::WD_IDLE;
					else if (wdCount_q + 34'h1 >= holdSel)
					begin
						wdState_q <= stw_types_pkg::WD_GRACE;
						wdCount_q <= 34'h0;
					end
					else
						wdCount_q <= wdCount_q + 34'h1;
				end
				default:
					wdState_q <= stw_types_pkg::WD_OFF;
			endcase
		end
	end

	// Registered pins: one cycle behind the state, glitch-free on the board
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			resetOut_n <= 1'b0;
			watchdogFaultOut_n <= 1'b1;
		end
		else
		begin
			resetOut_n <= supOk && (dualOutputPinout
				|| wdState_q != stw_types_pkg::WD_FAULT);
			watchdogFaultOut_n <= !dualOutputPinout
				|| wdState_q != stw_types_pkg::WD_FAULT;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	property p_uvReset;
		supState_q != stw_types_pkg::SUP_OK |=> !resetOut_n;
	endproperty
	a_uvReset: assert property (p_uvReset) else $error("reset not held while supply bad");

	property p_porHold;
		goHold && porFlag_q |=> holdTarget_q == SETTLE_CYCLES + $past(holdSel);
	endproperty
	a_porHold: assert property (p_porHold) else $error("power-on hold lacks settle time");

	property p_uvHold;
		goHold && !porFlag_q |=> holdTarget_q == $past(holdSel);
	endproperty
	a_uvHold: assert property (p_uvHold) else $error("recovery hold not the hold time");

	property p_andOut;
		!dualOutputPinout && wdState_q == stw_types_pkg::WD_FAULT |=> !resetOut_n
			&& watchdogFaultOut_n;
	endproperty
	a_andOut: assert property (p_andOut) else $error("fault not routed to reset");

	property p_suspend;
		!supOk |=> wdState_q == stw_types_pkg::WD_OFF ##1 watchdogFaultOut_n;
	endproperty
	a_suspend: assert property (p_suspend) else $error("watchdog ran during reset");

	property p_kick;
		supOk && wdEnabled && wdState_q == stw_types_pkg::WD_WINDOW && kickFell
			|=> wdCount_q == 34'h0 && wdState_q == stw_types_pkg::WD_WINDOW;
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not restart window");

	property p_capDis;
		capWindowMode && capDone && !capOk |-> !wdEnabled;
	endproperty
	a_capDis: assert property (p_capDis) else $error("bad capacitor left watchdog on");

	property p_codeDis;
		!hasEnablePin && hasScaleBit1 && scaleCode == 2'h1 |-> !wdEnabled;
	endproperty
	a_codeDis: assert property (p_codeDis) else $error("code 01 did not disable");

	property p_disable;
		supOk && !wdEnabled && wdState_q != stw_types_pkg::WD_OFF
			|=> wdState_q == stw_types_pkg::WD_IDLE ##1 watchdogFaultOut_n;
	endproperty
	a_disable: assert property (p_disable) else $error("disable kept the window");

	property p_enable;
		supOk && wdEnabled && wdState_q == stw_types_pkg::WD_IDLE
			|=> wdState_q == stw_types_pkg::WD_WINDOW && wdCount_q == 34'h0;
	endproperty
	a_enable: assert property (p_enable) else $error("enable did not open a window");

	property p_clamp;
		windowTarget_q <= WIN_MAX;
	endproperty
	a_clamp: assert property (p_clamp) else $error("window above clamp");

	property p_cFault;
		wdState_q == stw_types_pkg::WD_WINDOW ##1 wdState_q == stw_types_pkg::WD_FAULT;
	endproperty
	c_cFault: cover property (p_cFault);

	property p_cGraceKick;
		wdState_q == stw_types_pkg::WD_GRACE && kickFell ##1 wdState_q == stw_types_pkg::WD_WINDOW;
	endproperty
	c_cGraceKick: cover property (p_cGraceKick);

	property p_cRelease;
		$rose(resetOut_n);
	endproperty
	c_cRelease: cover property (p_cRelease);

endmodule

// [rtl/stw_types_pkg.sv]
// State types shared by the supervisor watchdog modules.
// Assumes one-hot encodings are wanted for every state machine.
package stw_types_pkg;

	// Supervisor: below threshold, counting the hold, released
	typedef enum logic [2:0] {
		SUP_LOW = 3'h1,
		SUP_HOLD = 3'h2,
		SUP_OK = 3'h4
	} stw_sup_state_t;

	// Watchdog phases
	typedef enum logic [4:0] {
		WD_OFF = 5'h01,
		WD_IDLE = 5'h02,
		WD_GRACE = 5'h04,
		WD_WINDOW = 5'h08,
		WD_FAULT = 5'h10
	} stw_wd_state_t;

	// Timing capacitor sense cycle
	typedef enum logic [2:0] {
		CAP_IDLE = 3'h1,
		CAP_CHARGE = 3'h2,
		CAP_DISCHARGE = 3'h4
	} stw_cap_state_t;

endpackage

// [tb/stw_host_model.sv]
// Host model: drives the kick pin and the enable pin of the watchdog.
// Assumes bench requests are one-cycle pulses or levels on the core clock.
`timescale 1ns/1ps
module stw_host_model (
	// Clock
	input wire logic clock,
	// Requests from the bench
	input wire logic kickReq,
	input wire logic enableReq,
	// Pins towards the device
	output logic kickInput,
	output logic watchdogEnablePin
);
	logic [1:0] lowCnt;

	// Idle level high, so only a real request makes a falling edge
	initial
	begin
		kickInput = 1'b1;
		lowCnt = 2'h0;
	end

	// Kick: three low cycles, long enough for a two-flop synchroniser
	always @(posedge clock)
	begin
		if (kickReq)
		begin
			kickInput <= 1'b0;
			lowCnt <= 2'h3;
		end
		else if (lowCnt != 2'h0)
		begin
			lowCnt <= lowCnt - 2'h1;
			kickInput <= (lowCnt == 2'h1);
		end
	end

	// Enable level may change at any time
	assign watchdogEnablePin = enableReq;
endmodule

// [tb/tb_stw_supervisor_watchdog.sv]
// Self-checking bench of the supervisor watchdog with shortened timing parameters.
// Assumes the host model drives kick and enable; supply, scale and straps are driven here.
`timescale 1ns/1ps
module tb_stw_supervisor_watchdog;
	localparam int HOLD = 20;
	localparam int SETTLE = 10;
	localparam int OPEN_HOLD = 8;
	localparam int BASE = 30;
	localparam int GRACE = 40;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic supplyBelowFalling = 1'b1;
	logic supplyAboveRising = 1'b0;
	logic kickReq = 1'b0;
	logic enableReq = 1'b0;
	logic [1:0] scaleCode = 2'h0;
	logic windowCapAboveRef = 1'b0;
	logic holdCapacitorOpen = 1'b0;
	logic [4:0] straps = 5'h14;
	logic kickInput, watchdogEnablePin, resetOut_n, watchdogFaultOut_n, faultSeen;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int faultCnt = 0;
	int tPower;

	// A fault shows on its own pin, or on reset for reset-only pinouts
	assign faultSeen = straps[4] ? !watchdogFaultOut_n : !resetOut_n;

	// Clock, 100 ns period
	initial
	begin
		forever #50 clock = ~clock;
	end

	// Fault cycles counted, so short pulses between samples are never missed
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (faultSeen === 1'b1)
			faultCnt <= faultCnt + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			stop_test();
		end
	end

	stw_host_model i_stw_host_model (.clock(clock), .kickReq(kickReq), .enableReq(enableReq),
		.kickInput(kickInput), .watchdogEnablePin(watchdogEnablePin));

	stw_supervisor_watchdog #(.HOLD_CYCLES(34'(HOLD)), .SETTLE_CYCLES(34'(SETTLE)),
		.OPEN_HOLD_CYCLES(34'(OPEN_HOLD)), .WINDOW_BASE_CYCLES(34'(BASE)),
		.GRACE_CYCLES(34'(GRACE)), .SCALE_SHIFT(1)) i_stw_supervisor_watchdog (
		.clock(clock), .reset_n(reset_n), .supplyBelowFalling(supplyBelowFalling),
		.supplyAboveRising(supplyAboveRising), .kickInput(kickInput),
		.watchdogEnablePin(watchdogEnablePin), .scaleSelectBit0(scaleCode[0]),
		.scaleSelectBit1(scaleCode[1]), .windowCapAboveRef(windowCapAboveRef),
		.holdCapacitorOpen(holdCapacitorOpen), .windowCapCharge(), .windowCapDischarge(),
		.dualOutputPinout(straps[4]), .hasEnablePin(straps[3]), .hasScaleBit1(straps[2]),
		.capWindowMode(straps[1]), .capHoldMode(straps[0]), .resetOut_n(resetOut_n),
		.watchdogFaultOut_n(watchdogFaultOut_n));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	// Latency slack of the synchronisers is kept out of the exact figures
	task automatic in_range(input string name, input int v, input int lo, input int hi);
		check(name, 32'(v >= lo && v <= hi), 32'h1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	function automatic bit cond(input int which);
		case (which)
			0: return faultSeen === 1'b1;
			1: return faultSeen === 1'b0;
			2: return resetOut_n === 1'b1;
			default: return resetOut_n === 1'b0;
		endcase
	endfunction

	// Cycles until a condition holds, bounded; sampled just after the edge settles
	task automatic wait_for(input int which, input int lim, output int n);
		n = 0;
		while (n < lim && !cond(which))
		begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	task automatic kick;
		tick(1);
		kickReq <= 1'b1;
		tick(1);
		kickReq <= 1'b0;
	endtask

	// Raise the supply and count cycles until reset releases
	task automatic supply_ok(output int t);
		supplyBelowFalling <= 1'b0;
		supplyAboveRising <= 1'b1;
		wait_for(2, 400, t);
	endtask

	// Straps change only while reset is held
	task automatic power_up(input logic [4:0] s, output int t);
		tick(1);
		reset_n <= 1'b0;
		straps <= s;
		supplyBelowFalling <= 1'b1;
		supplyAboveRising <= 1'b0;
		tick(20);
		reset_n <= 1'b1;
		tick(1);
		supply_ok(t);
	endtask

	task automatic undervolt(output int t);
		int n;
		tick(1);
		supplyBelowFalling <= 1'b1;
		supplyAboveRising <= 1'b0;
		wait_for(3, 20, n);
		in_range("uv reset delay", n, 2, 6);
		tick(10);
		check("fault pin in uv", watchdogFaultOut_n, 32'h1);
		supply_ok(t);
	endtask

	task automatic t_power;
		int n;
		int t;
		power_up(5'h14, tPower);
		in_range("power-up hold", tPower, HOLD + SETTLE, HOLD + SETTLE + 6);
		wait_for(0, 100, n);
		in_range("grace to fault", n, GRACE, GRACE + 6);
		check("reset in fault", resetOut_n, 32'h1);
		wait_for(1, 100, n);
		check("fault hold", n, HOLD);
		undervolt(t);
		check("recovery hold", tPower - t, SETTLE);
		tick(1);
		holdCapacitorOpen <= 1'b1;
		power_up(5'h15, t);
		check("open hold", tPower - t, HOLD - OPEN_HOLD);
		tick(1);
		holdCapacitorOpen <= 1'b0;
		$display("t_power done");
	endtask

	task automatic t_kicks;
		logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
		int mult [3] = '{1, 2, 4};
		int n;
		int d0;
		int f;
		power_up(5'h14, n);
		f = faultCnt;
		repeat (8)
		begin
			kick();
			tick(20);
		end
		check("kept alive", faultCnt - f, 0);
		for (int i = 0; i < 3; i++)
		begin
			tick(1);
			scaleCode <= codes[i];
			tick(5);
			kick();
			wait_for(0, 300, n);
			if (i == 0)
				d0 = n;
			check("scaled window", n - d0, BASE * mult[i] - BASE);
			wait_for(1, 100, n);
		end
		in_range("base window", d0, BASE, BASE + 8);
		$display("t_kicks done");
	endtask

	task automatic t_disable;
		int n;
		int f;
		tick(1);
		scaleCode <= 2'h1;
		power_up(5'h04, n);
		f = faultCnt;
		tick(200);
		check("code disable", faultCnt - f, 0);
		check("fault pin unused", watchdogFaultOut_n, 32'h1);
		undervolt(n);
		tick(1);
		scaleCode <= 2'h0;
		wait_for(0, 100, n);
		in_range("enable to fault", n, BASE, BASE + 8);
		wait_for(1, 100, n);
		check("fault on reset", n, HOLD);
		$display("t_disable done");
	endtask

	task automatic t_enable_pin;
		int n;
		int f;
		tick(1);
		scaleCode <= 2'h1;
		enableReq <= 1'b0;
		power_up(5'h1c, n);
		f = faultCnt;
		tick(150);
		check("pin low", faultCnt - f, 0);
		enableReq <= 1'b1;
		wait_for(0, 100, n);
		in_range("pin enable to fault", n, BASE, BASE + 8);
		wait_for(1, 100, n);
		tick(10);
		kick();
		tick(10);
		enableReq <= 1'b0;
		f = faultCnt;
		tick(100);
		check("disable mid-window", faultCnt - f, 0);
		$display("t_enable_pin done");
	endtask

	// Capacitor above the reference at once is rejected; a later change is not sensed
	task automatic t_cap_bad;
		int n;
		int f;
		tick(1);
		scaleCode <= 2'h0;
		windowCapAboveRef <= 1'b1;
		power_up(5'h16, n);
		f = faultCnt;
		tick(150);
		windowCapAboveRef <= 1'b0;
		tick(200);
		check("cap disable", faultCnt - f, 0);
		$display("t_cap_bad done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		t_power();
		t_kicks();
		t_disable();
		t_enable_pin();
		t_cap_bad();
		stop_test();
	end
endmodule
